// ===== scc_pkg.sv
package scc_pkg;
  // Device register byte addresses on the device's own port.
  localparam logic [11:0] A_CLKGEN  = 12'h030;
  localparam logic [11:0] A_SRSTAT  = 12'h031;
  localparam logic [11:0] A_SRDELAY = 12'h032;
  localparam logic [11:0] A_CALTRIG = 12'h050;
  localparam logic [11:0] A_BGCAL   = 12'h057;
  localparam logic [11:0] A_LINKCTL = 12'h061;
  localparam logic [11:0] A_DECIM   = 12'h062;
  localparam logic [11:0] A_OFFSET  = 12'h063;
  localparam logic [11:0] A_TCAL    = 12'h066;
  localparam logic [11:0] A_DEVSTAT = 12'h06A;
  // Field positions.
  localparam int B_RCVR_ON  = 7;
  localparam int B_PROC_ON  = 6;
  localparam int B_SEEN_CLR = 5;
  localparam int B_MARG_CLR = 4;
  localparam int B_SEEN     = 7;
  localparam int B_MARG     = 6;
  localparam int B_CALTRIG  = 3;
  localparam int B_BGSEL    = 0;
  localparam int B_CONTSEL  = 1;
  localparam int B_TCAL_ON  = 0;
  localparam int B_LINK_ON  = 0;
  // Reset value, masks and constants.
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] CLR_MASK   = 8'h30;
  localparam logic [7:0] TRIG_MASK  = 8'h08;
  localparam logic [11:0] HOLD_CODE = 12'h800;
  localparam int ILA_MFRAMES        = 4;
  // Host register byte offsets on AHB-Lite.
  localparam logic [7:0] H_DEVADDR  = 8'h00;
  localparam logic [7:0] H_DEVWDATA = 8'h04;
  localparam logic [7:0] H_CMD      = 8'h08;
  localparam logic [7:0] H_STATUS   = 8'h0C;
  localparam logic [7:0] H_LINKCTL  = 8'h10;
  localparam int HB_WRITE    = 0;
  localparam int HB_READ     = 1;
  localparam int HB_SREF_GEN = 0;
  localparam int HB_SYNC_REQ = 1;

  typedef enum logic [2:0] {LINK_OFF, LINK_CGS, LINK_WAIT, LINK_ILA, LINK_DATA} scc_link_t;
  typedef enum logic [1:0] {CAL_IDLE, CAL_FG, CAL_BG} scc_cal_t;

  // Decimation code to factor; unknown codes fall back to bypass.
  function automatic logic [5:0] scc_dec_factor(input logic [2:0] code);
    case (code)
      3'h1:    scc_dec_factor = 6'h04;
      3'h2:    scc_dec_factor = 6'h08;
      3'h3:    scc_dec_factor = 6'h0A;
      3'h4:    scc_dec_factor = 6'h10;
      3'h5:    scc_dec_factor = 6'h14;
      3'h6:    scc_dec_factor = 6'h20;
      default: scc_dec_factor = 6'h01;
    endcase
  endfunction
endpackage

// ===== scc_if.sv
`timescale 1ns/1ns
`default_nettype none
interface scc_if;
  logic [11:0] reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_ack;
  logic        sysref;
  logic        sync_n;

  modport dev (input reg_addr, reg_wr, reg_rd, reg_wdata, sysref, sync_n,
               output reg_rdata, reg_ack);
  modport host (output reg_addr, reg_wr, reg_rd, reg_wdata, sysref, sync_n,
                input reg_rdata, reg_ack);
endinterface
`default_nettype wire

// ===== scc_device.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - four-bit delay shifts sampled SYSREF
// - sticky flag on delayed SYSREF rising edge
// - sticky flag on marginal setup or hold
// - seen-clear bit clears the seen flag
// - marginal-clear bit clears the marginal flag
// - receiver and processing enables gate SYSREF
// - host sweeps delay and loads clean centre
// - NCO phase reset during lane alignment
// - receivers release SYNC~ in one LMFC
// - factor one outputs raw samples every cycle
// - other factors output I/Q at reduced rate
// - foreground calibration holds a static output code
// - self-clearing trigger starts foreground calibration
// - foreground calibration ends in bounded cycles
// - calibration resets logic; host re-toggles link
// - five cores, one offline, swapped together
// - fixed rotation rate, not adjustable
// - host sets background bits then trigger
// - offset adjust ignored in background mode
// - timing enable lengthens foreground calibration
// - captured SYSREF edge aligns LMFC
// - SYNC~ low requests, high releases
module scc_device #(
  parameter int unsigned CAL_CYCLES  = 102_000_000,
  parameter int unsigned TCAL_CYCLES = 227_000_000,
  parameter int unsigned BG_CYCLES   = 816_000_000,
  parameter int unsigned LMFC_CYCLES = 32,
  parameter int unsigned CORES       = 5
) (
  // Clock and reset.
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  // Link and register port.
  scc_if.dev               bus,
  // Converter side.
  input  wire logic [11:0] i_sample,
  input  wire logic [3:0]  i_sysref_skew,
  output logic [14:0]      o_data_i,
  output logic [14:0]      o_data_q,
  output logic             o_data_valid,
  output logic             o_nco_reset,
  output logic             o_lmfc_edge,
  output logic [2:0]       o_offline_core
);
  localparam int unsigned ROT_CYCLES = BG_CYCLES / CORES;

  logic [7:0]  clkgen_reg, delay_reg, bgcal_reg, tcal_reg;
  logic [7:0]  linkctl_reg, decim_reg, offset_reg, rdata_reg;
  logic        seen_reg, marg_reg, prev_reg, ack_reg, rearm_reg;
  logic [15:0] taps_reg;
  logic [31:0] cal_cnt_reg;
  logic [7:0]  lmfc_cnt_reg, ila_cnt_reg;
  logic [5:0]  dec_cnt_reg;
  logic [1:0]  nco_ph_reg;
  logic [2:0]  core_reg;
  scc_pkg::scc_cal_t  cal_reg;
  scc_pkg::scc_link_t link_reg;
  logic        sref_on, sref_dly, sref_edge, marg_hit, link_on;
  logic        wr_clkgen, cal_start, bg_req;
  logic [5:0]  factor;
  logic [11:0] adj;
  logic [14:0] smp;

  //////////////////////////////////////////////////////////////////////////
  // Register writes.
  assign wr_clkgen = bus.reg_wr && bus.reg_addr == scc_pkg::A_CLKGEN;
  assign cal_start = bus.reg_wr && bus.reg_addr == scc_pkg::A_CALTRIG &&
                     bus.reg_wdata[scc_pkg::B_CALTRIG];

  // Configuration registers; clear and trigger bits are never stored.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      clkgen_reg  <= scc_pkg::RST_ZERO;
      delay_reg   <= scc_pkg::RST_ZERO;
      bgcal_reg   <= scc_pkg::RST_ZERO;
      tcal_reg    <= scc_pkg::RST_ZERO;
      linkctl_reg <= scc_pkg::RST_ZERO;
      decim_reg   <= scc_pkg::RST_ZERO;
      offset_reg  <= scc_pkg::RST_ZERO;
    end else if (bus.reg_wr) begin
      case (bus.reg_addr)
        scc_pkg::A_CLKGEN:  clkgen_reg  <= bus.reg_wdata & ~scc_pkg::CLR_MASK;
        scc_pkg::A_SRDELAY: delay_reg   <= bus.reg_wdata;
        scc_pkg::A_BGCAL:   bgcal_reg   <= bus.reg_wdata;
        scc_pkg::A_TCAL:    tcal_reg    <= bus.reg_wdata;
        scc_pkg::A_LINKCTL: linkctl_reg <= bus.reg_wdata;
        scc_pkg::A_DECIM:   decim_reg   <= bus.reg_wdata;
        scc_pkg::A_OFFSET:  offset_reg  <= bus.reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data and acknowledge follow a strobe by one cycle.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rdata_reg <= scc_pkg::RST_ZERO;
      ack_reg   <= 1'b0;
    end else begin
      ack_reg <= bus.reg_wr | bus.reg_rd;
      if (bus.reg_rd) begin
        case (bus.reg_addr)
          scc_pkg::A_CLKGEN:  rdata_reg <= clkgen_reg;
          scc_pkg::A_SRSTAT:  rdata_reg <= {seen_reg, marg_reg, 6'h00};
          scc_pkg::A_SRDELAY: rdata_reg <= delay_reg;
          scc_pkg::A_BGCAL:   rdata_reg <= bgcal_reg;
          scc_pkg::A_TCAL:    rdata_reg <= tcal_reg;
          scc_pkg::A_LINKCTL: rdata_reg <= linkctl_reg;
          scc_pkg::A_DECIM:   rdata_reg <= decim_reg;
          scc_pkg::A_OFFSET:  rdata_reg <= offset_reg;
          scc_pkg::A_DEVSTAT: rdata_reg <= {cal_reg == scc_pkg::CAL_FG, link_reg, core_reg,
                                            cal_reg == scc_pkg::CAL_BG};
          default:            rdata_reg <= scc_pkg::RST_ZERO;
        endcase
      end
    end
  end
  assign bus.reg_rdata = rdata_reg;
  assign bus.reg_ack   = ack_reg;

  //////////////////////////////////////////////////////////////////////////
  // SYSREF capture: a tap line stands in for the adjustable delay.
  assign sref_on = clkgen_reg[scc_pkg::B_RCVR_ON] & clkgen_reg[scc_pkg::B_PROC_ON];

  // Taps fill only while the receiver is on.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !clkgen_reg[scc_pkg::B_RCVR_ON]) begin
      taps_reg <= 16'h0000;
      prev_reg <= 1'b0;
    end else begin
      taps_reg <= {taps_reg[14:0], bus.sysref};
      prev_reg <= sref_dly;
    end
  end
  assign sref_dly  = taps_reg[delay_reg[3:0]];
  assign sref_edge = sref_on & sref_dly & ~prev_reg;
  // An edge landing at or one tap after the skew point violates setup or hold.
  assign marg_hit  = sref_edge && (delay_reg[3:0] == i_sysref_skew ||
                                   delay_reg[3:0] == 4'(i_sysref_skew + 4'h1));

  // Sticky flags; a clear written in the same cycle wins.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      seen_reg <= 1'b0;
      marg_reg <= 1'b0;
    end else begin
      if (wr_clkgen && bus.reg_wdata[scc_pkg::B_SEEN_CLR])
        seen_reg <= 1'b0;
      else if (sref_edge)
        seen_reg <= 1'b1;
      if (wr_clkgen && bus.reg_wdata[scc_pkg::B_MARG_CLR])
        marg_reg <= 1'b0;
      else if (marg_hit)
        marg_reg <= 1'b1;
    end
  end

  // LMFC counter realigned by each captured edge.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || sref_edge)
      lmfc_cnt_reg <= 8'h00;
    else if (lmfc_cnt_reg == 8'(LMFC_CYCLES - 1))
      lmfc_cnt_reg <= 8'h00;
    else
      lmfc_cnt_reg <= lmfc_cnt_reg + 8'h01;
  end
  assign o_lmfc_edge = lmfc_cnt_reg == 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // Calibration sequencer.
  assign bg_req = bgcal_reg[scc_pkg::B_BGSEL] & bgcal_reg[scc_pkg::B_CONTSEL];

  // A trigger restarts the sequencer from any state.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cal_reg     <= scc_pkg::CAL_IDLE;
      cal_cnt_reg <= 32'h0000_0000;
      core_reg    <= 3'h0;
    end else if (cal_start) begin
      cal_reg     <= scc_pkg::CAL_FG;
      cal_cnt_reg <= tcal_reg[scc_pkg::B_TCAL_ON] ? TCAL_CYCLES - 1
                                                 : CAL_CYCLES - 1;
      core_reg    <= 3'h0;
    end else begin
      case (cal_reg)
        scc_pkg::CAL_FG: begin
          if (cal_cnt_reg == 32'h0000_0000) begin
            cal_reg     <= bg_req ? scc_pkg::CAL_BG : scc_pkg::CAL_IDLE;
            cal_cnt_reg <= ROT_CYCLES - 1;
          end else begin
            cal_cnt_reg <= cal_cnt_reg - 32'h0000_0001;
          end
        end
        scc_pkg::CAL_BG: begin
          if (!bg_req) begin
            cal_reg <= scc_pkg::CAL_IDLE;
          end else if (cal_cnt_reg == 32'h0000_0000) begin
            cal_cnt_reg <= ROT_CYCLES - 1;
            core_reg    <= core_reg == 3'(CORES - 1) ? 3'h0 : core_reg + 3'h1;
          end else begin
            cal_cnt_reg <= cal_cnt_reg - 32'h0000_0001;
          end
        end
        default: cal_reg <= scc_pkg::CAL_IDLE;
      endcase
    end
  end
  assign o_offline_core = core_reg;

  //////////////////////////////////////////////////////////////////////////
  // Link state; after a calibration the link bit must go low then high.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset)
      rearm_reg <= 1'b0;
    else if (cal_start)
      rearm_reg <= 1'b1;
    else if (!linkctl_reg[scc_pkg::B_LINK_ON])
      rearm_reg <= 1'b0;
  end
  assign link_on = linkctl_reg[scc_pkg::B_LINK_ON] & ~rearm_reg;

  // Code groups until SYNC~ releases, then alignment from an LMFC edge.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !link_on) begin
      link_reg    <= scc_pkg::LINK_OFF;
      ila_cnt_reg <= 8'h00;
    end else if (!bus.sync_n && link_reg != scc_pkg::LINK_OFF) begin
      link_reg <= scc_pkg::LINK_CGS;
    end else begin
      case (link_reg)
        scc_pkg::LINK_OFF: link_reg <= scc_pkg::LINK_CGS;
        scc_pkg::LINK_CGS: if (bus.sync_n) link_reg <= scc_pkg::LINK_WAIT;
        scc_pkg::LINK_WAIT: begin
          ila_cnt_reg <= 8'h00;
          if (o_lmfc_edge) link_reg <= scc_pkg::LINK_ILA;
        end
        scc_pkg::LINK_ILA: begin
          if (o_lmfc_edge) ila_cnt_reg <= ila_cnt_reg + 8'h01;
          if (o_lmfc_edge && ila_cnt_reg == 8'(scc_pkg::ILA_MFRAMES - 1))
            link_reg <= scc_pkg::LINK_DATA;
        end
        scc_pkg::LINK_DATA: link_reg <= scc_pkg::LINK_DATA;
        default: link_reg <= scc_pkg::LINK_OFF;
      endcase
    end
  end
  assign o_nco_reset = link_reg == scc_pkg::LINK_ILA;

  // Quarter-rate NCO phase, held at zero through alignment.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || o_nco_reset)
      nco_ph_reg <= 2'h0;
    else
      nco_ph_reg <= nco_ph_reg + 2'h1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Output datapath.
  assign factor = scc_pkg::scc_dec_factor(decim_reg[2:0]);
  assign adj = (cal_reg == scc_pkg::CAL_BG) ? i_sample
             : 12'(i_sample + {{4{offset_reg[7]}}, offset_reg});
  assign smp = {{4{~adj[11]}}, adj[10:0]};

  // Decimation phase counter.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || dec_cnt_reg >= 6'(factor - 6'h01))
      dec_cnt_reg <= 6'h00;
    else
      dec_cnt_reg <= dec_cnt_reg + 6'h01;
  end

  // Bypass, mixed I/Q, or the static code during foreground calibration.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_data_i     <= 15'h0000;
      o_data_q     <= 15'h0000;
      o_data_valid <= 1'b0;
    end else if (factor == 6'h01) begin
      o_data_valid <= 1'b1;
      o_data_i     <= {3'h0, (cal_reg == scc_pkg::CAL_FG) ? scc_pkg::HOLD_CODE : adj};
      o_data_q     <= 15'h0000;
    end else begin
      o_data_valid <= dec_cnt_reg == 6'h00;
      if (cal_reg == scc_pkg::CAL_FG) begin
        o_data_i <= 15'h0000;
        o_data_q <= 15'h0000;
      end else if (dec_cnt_reg == 6'h00) begin
        o_data_i <= nco_ph_reg[0] ? 15'h0000 : (nco_ph_reg[1] ? 15'(-smp) : smp);
        o_data_q <= !nco_ph_reg[0] ? 15'h0000 : (nco_ph_reg[1] ? smp : 15'(-smp));
      end
    end
  end
endmodule
`default_nettype wire

// ===== scc_host.sv
`timescale 1ns/1ns
`default_nettype none
module scc_host #(
  parameter int unsigned SYSREF_PERIOD = 64,
  parameter int unsigned LMFC_CYCLES   = 32
) (
  // Clock and reset.
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  // AHB-Lite slave.
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  // Link to the device.
  scc_if.host              bus
);
  logic [11:0] devaddr_reg;
  logic [7:0]  devwdata_reg, lastrd_reg, sref_cnt_reg;
  logic [1:0]  linkctl_reg;
  logic        wpend_reg, busy_reg, wr_reg, rd_reg, sref_reg, sync_n_reg;
  logic [7:0]  waddr_reg;
  logic        take, start_wr, start_rd;

  //////////////////////////////////////////////////////////////////////////
  // Zero-wait slave, always OKAY.
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign take = i_hsel && i_hready && i_htrans[1] && i_hsize == 3'h2;

  // Address phase capture and registered read data.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      wpend_reg <= 1'b0;
      waddr_reg <= 8'h00;
      o_hrdata  <= 32'h0000_0000;
    end else begin
      wpend_reg <= take && i_hwrite;
      waddr_reg <= i_haddr;
      if (take && !i_hwrite) begin
        case (i_haddr)
          scc_pkg::H_DEVADDR:  o_hrdata <= {20'h0_0000, devaddr_reg};
          scc_pkg::H_DEVWDATA: o_hrdata <= {24'h00_0000, devwdata_reg};
          scc_pkg::H_STATUS:   o_hrdata <= {16'h0000, lastrd_reg, 7'h00, busy_reg};
          scc_pkg::H_LINKCTL:  o_hrdata <= {30'h0000_0000, linkctl_reg};
          default:             o_hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Data phase writes; command bits are pulses, ignored while busy.
  assign start_wr = wpend_reg && waddr_reg == scc_pkg::H_CMD && !busy_reg &&
                    i_hwdata[scc_pkg::HB_WRITE];
  assign start_rd = wpend_reg && waddr_reg == scc_pkg::H_CMD && !busy_reg &&
                    !i_hwdata[scc_pkg::HB_WRITE] && i_hwdata[scc_pkg::HB_READ];

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      devaddr_reg  <= 12'h000;
      devwdata_reg <= 8'h00;
      linkctl_reg  <= 2'h2;
    end else if (wpend_reg) begin
      case (waddr_reg)
        scc_pkg::H_DEVADDR:  devaddr_reg  <= i_hwdata[11:0];
        scc_pkg::H_DEVWDATA: devwdata_reg <= i_hwdata[7:0];
        scc_pkg::H_LINKCTL:  linkctl_reg  <= i_hwdata[1:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Device register access: one strobe, then wait for the acknowledge.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      busy_reg   <= 1'b0;
      wr_reg     <= 1'b0;
      rd_reg     <= 1'b0;
      lastrd_reg <= 8'h00;
    end else begin
      wr_reg <= start_wr;
      rd_reg <= start_rd;
      if (start_wr || start_rd)
        busy_reg <= 1'b1;
      else if (bus.reg_ack) begin
        busy_reg   <= 1'b0;
        lastrd_reg <= bus.reg_rdata;
      end
    end
  end
  assign bus.reg_addr  = devaddr_reg;
  assign bus.reg_wdata = devwdata_reg;
  assign bus.reg_wr    = wr_reg;
  assign bus.reg_rd    = rd_reg;

  //////////////////////////////////////////////////////////////////////////
  // Periodic SYSREF, a whole number of LMFC periods long.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || sref_cnt_reg == 8'(SYSREF_PERIOD - 1))
      sref_cnt_reg <= 8'h00;
    else
      sref_cnt_reg <= sref_cnt_reg + 8'h01;
  end

  // SYNC~ falls at once on request, rises only on an LMFC boundary.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      sref_reg   <= 1'b0;
      sync_n_reg <= 1'b0;
    end else begin
      sref_reg <= linkctl_reg[scc_pkg::HB_SREF_GEN] &&
                  sref_cnt_reg < 8'(SYSREF_PERIOD / 2);
      if (linkctl_reg[scc_pkg::HB_SYNC_REQ])
        sync_n_reg <= 1'b0;
      else if (8'(sref_cnt_reg % 8'(LMFC_CYCLES)) == 8'h00)
        sync_n_reg <= 1'b1;
    end
  end
  assign bus.sysref = sref_reg;
  assign bus.sync_n = sync_n_reg;
endmodule
`default_nettype wire

// ===== scc_props.sv
`timescale 1ns/1ns
`default_nettype none
// Checks the register link between the host end and the device end.
module scc_props (
  // Clock and reset.
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  // Link signals.
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic [7:0]  reg_rdata,
  input  wire logic        reg_ack,
  input  wire logic        sysref,
  input  wire logic        sync_n
);
  logic [3:0] dly_reg;
  logic [1:0] en_reg;
  logic [1:0] stk_reg;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////
  // Keeps the last delay and enable values that were written.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      dly_reg <= 4'h0;
      en_reg  <= 2'h0;
    end else if (reg_wr && reg_addr == scc_pkg::A_SRDELAY) begin
      dly_reg <= reg_wdata[3:0];
    end else if (reg_wr && reg_addr == scc_pkg::A_CLKGEN) begin
      en_reg <= reg_wdata[7:6];
    end
  end
  // Remembers flags read as set until their clear bit is written.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      stk_reg <= 2'h0;
    end else if (reg_wr && reg_addr == scc_pkg::A_CLKGEN) begin
      stk_reg <= stk_reg & ~reg_wdata[5:4];
    end else if (reg_ack && $past(reg_rd && reg_addr == scc_pkg::A_SRSTAT)) begin
      stk_reg <= stk_reg | reg_rdata[7:6];
    end
  end
  ////////////////////////////////////////
  // A read strobe at one address followed by its acknowledge.
  sequence s_rd(a);
    reg_rd && reg_addr == a ##1 reg_ack;
  endsequence
  a_ack_strobe: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("acknowledge missing after a strobe");
  a_ack_cause: assert property (reg_ack |-> $past(reg_wr || reg_rd))
    else $error("acknowledge without a strobe");
  a_one_strobe: assert property (!(reg_wr && reg_rd))
    else $error("read and write strobes together");
  a_delay_kept: assert property (
    s_rd(scc_pkg::A_SRDELAY) |-> reg_rdata[3:0] == dly_reg)
    else $error("delay setting lost");
  a_enable_kept: assert property (
    s_rd(scc_pkg::A_CLKGEN) |-> reg_rdata[7:6] == en_reg)
    else $error("enable bits lost");
  a_clear_reads: assert property (
    s_rd(scc_pkg::A_CLKGEN) |-> reg_rdata[5:4] == 2'h0)
    else $error("clear bits read back set");
  a_trig_reads: assert property (
    s_rd(scc_pkg::A_CALTRIG) |-> !reg_rdata[scc_pkg::B_CALTRIG])
    else $error("calibration trigger did not self clear");
  a_flag_sticky: assert property (
    s_rd(scc_pkg::A_SRSTAT) |-> (reg_rdata[7:6] & stk_reg) == stk_reg)
    else $error("capture flag cleared by itself");
endmodule
`default_nettype wire

// ===== sysref_capture_and_calibration_ctl_test.sv
`timescale 1ns/1ns
`default_nettype none
module sysref_capture_and_calibration_ctl_test;
  // Bench signals.
  logic        sys_clk   = 1'h0;
  logic        reset     = 1'h1;
  logic        hsel      = 1'h1;
  logic [7:0]  haddr     = 8'h00;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'h0;
  logic [31:0] hwdata    = 32'h0000_0000;
  logic [11:0] sample    = 12'h000;
  logic [3:0]  skew      = 4'hB;
  logic        rchk      = 1'h0;
  logic        hold      = 1'h0;
  logic [31:0] seed      = 32'h0000_7853;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic [14:0] di;
  logic [14:0] dq;
  logic        dv;
  logic        nco;
  logic        lmfc;
  logic [2:0]  core;
  logic [2:0]  prev;
  logic [3:0]  dl;
  logic [31:0] rd;
  logic [15:0] note;
  logic [15:0] expq[$];
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc       = 0;
  int          n;
  int          mx;
  localparam int FAC[8] = '{1, 4, 8, 10, 16, 20, 32, 1};
  ////////////////////////////////////////
  scc_if i_scc_if ();
  scc_host i_scc_host (.i_sys_clk(sys_clk),
    .i_reset(reset), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
    .o_hresp(hresp), .o_hrdata(hrdata), .bus(i_scc_if.host));
  scc_device #(.CAL_CYCLES(20), .TCAL_CYCLES(40), .BG_CYCLES(50)) i_scc_device (
    .i_sys_clk(sys_clk), .i_reset(reset), .bus(i_scc_if.dev),
    .i_sample(sample), .i_sysref_skew(skew), .o_data_i(di), .o_data_q(dq),
    .o_data_valid(dv), .o_nco_reset(nco), .o_lmfc_edge(lmfc), .o_offline_core(core));
  scc_props i_scc_props (.i_sys_clk(sys_clk), .i_reset(reset),
    .reg_addr(i_scc_if.reg_addr), .reg_wr(i_scc_if.reg_wr), .reg_rd(i_scc_if.reg_rd),
    .reg_wdata(i_scc_if.reg_wdata), .reg_rdata(i_scc_if.reg_rdata),
    .reg_ack(i_scc_if.reg_ack), .sysref(i_scc_if.sysref), .sync_n(i_scc_if.sync_n));
  ////////////////////////////////////////
  // Clock, random samples and the hang limit.
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    seed <= {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    if (!hold) sample <= seed[11:0];
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  // Compares each checked status read with the oldest note.
  always @(posedge sys_clk) begin
    if (rchk === 1'h1 && hready === 1'h1) begin
      note = expq.pop_front();
      chk("device read", {24'h0, note[7:0]}, {24'h0, hrdata[15:8] & note[15:8]});
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic pause(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // One single AHB-Lite word transfer; the last read word lands in rd.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    rchk <= c;
    do @(posedge sys_clk); while (hready !== 1'h1);
    rd = hrdata;
    rchk <= 1'h0;
  endtask
  task automatic idle();
    do ahb(1'h0, scc_pkg::H_STATUS, 32'h0000_0000, 1'h0); while (rd[0] !== 1'h0);
  endtask
  task automatic dev_wr(input logic [11:0] a, input logic [7:0] d);
    ahb(1'h1, scc_pkg::H_DEVADDR, {20'h0_0000, a}, 1'h0);
    ahb(1'h1, scc_pkg::H_DEVWDATA, {24'h00_0000, d}, 1'h0);
    ahb(1'h1, scc_pkg::H_CMD, 32'h0000_0001, 1'h0);
    idle();
  endtask
  task automatic dev_rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
    ahb(1'h1, scc_pkg::H_DEVADDR, {20'h0_0000, a}, 1'h0);
    ahb(1'h1, scc_pkg::H_CMD, 32'h0000_0002, 1'h0);
    idle();
    expq.push_back({m, e});
    ahb(1'h0, scc_pkg::H_STATUS, 32'h0000_0000, 1'h1);
  endtask
  ////////////////////////////////////////
  // Main sequence of scenarios.
  initial begin
    pause(2);
    reset <= 1'h0;
    dev_rd(scc_pkg::A_CLKGEN, 8'h00, 8'hFF);
    dev_wr(scc_pkg::A_SRSTAT, 8'hC0);
    dev_rd(scc_pkg::A_SRSTAT, 8'h00, 8'hFF);
    ahb(1'h0, 8'h14, 32'h0000_0000, 1'h0);
    chk("unmapped read", 32'h0000_0000, rd);
    for (int k = 0; k < 4; k++) begin
      dl = seed[3:0];
      dev_wr(scc_pkg::A_SRDELAY, {4'h0, dl});
      dev_rd(scc_pkg::A_SRDELAY, {4'h0, dl}, 8'hFF);
    end
    // Capture flags: enables, marginal timing, stickiness and clears.
    dev_wr(scc_pkg::A_SRDELAY, 8'h03);
    ahb(1'h1, scc_pkg::H_LINKCTL, 32'h0000_0001, 1'h0);
    pause(150);
    dev_rd(scc_pkg::A_SRSTAT, 8'h00, 8'hC0);
    dev_wr(scc_pkg::A_CLKGEN, 8'h80);
    pause(150);
    dev_rd(scc_pkg::A_SRSTAT, 8'h00, 8'hC0);
    dev_wr(scc_pkg::A_CLKGEN, 8'hC0);
    pause(150);
    dev_rd(scc_pkg::A_SRSTAT, 8'h80, 8'hC0);
    skew <= 4'h2;
    pause(150);
    dev_rd(scc_pkg::A_SRSTAT, 8'hC0, 8'hC0);
    dev_wr(scc_pkg::A_CLKGEN, 8'h00);
    pause(150);
    dev_rd(scc_pkg::A_SRSTAT, 8'hC0, 8'hC0);
    dev_wr(scc_pkg::A_CLKGEN, 8'h20);
    dev_rd(scc_pkg::A_SRSTAT, 8'h40, 8'hC0);
    dev_wr(scc_pkg::A_CLKGEN, 8'h10);
    dev_rd(scc_pkg::A_SRSTAT, 8'h00, 8'hC0);
    dev_wr(scc_pkg::A_CLKGEN, 8'hF0);
    dev_rd(scc_pkg::A_CLKGEN, 8'hC0, 8'hFF);
    // Foreground calibration with and without timing calibration.
    hold <= 1'h1;
    for (int t = 0; t < 2; t++) begin
      dev_wr(scc_pkg::A_TCAL, 8'(t));
      dev_wr(scc_pkg::A_CALTRIG, scc_pkg::TRIG_MASK);
      pause(3);
      chk("held code", 32'h0000_0800, di);
      pause(25);
      chk("cal end", (t == 0) ? {20'h0_0000, sample} : 32'h0000_0800, di);
      pause(40);
      chk("raw data", sample, di);
    end
    dev_rd(scc_pkg::A_CALTRIG, 8'h00, 8'hFF);
    hold <= 1'h0;
    // Output rate for every decimation code.
    for (int c = 0; c < 8; c++) begin
      dev_wr(scc_pkg::A_DECIM, 8'(c));
      pause(40);
      n = 0;
      repeat (160) begin
        @(posedge sys_clk);
        if (dv === 1'h1) n++;
      end
      chk("valid count", 32'(160 / FAC[c]), 32'(n));
    end
    // Background rotation of the spare core.
    dev_wr(scc_pkg::A_DECIM, 8'h00);
    dev_wr(scc_pkg::A_BGCAL, 8'h03);
    dev_wr(scc_pkg::A_CALTRIG, scc_pkg::TRIG_MASK);
    pause(40);
    n = 0;
    mx = 0;
    prev = core;
    repeat (100) begin
      @(posedge sys_clk);
      if (core !== prev) n++;
      if (core > mx) mx = core;
      prev = core;
    end
    chk("core swaps", 32'h0000_000A, 32'(n));
    chk("core max", 32'h0000_0004, 32'(mx));
    hold <= 1'h1;
    dev_wr(scc_pkg::A_OFFSET, 8'h10);
    pause(3);
    chk("bg offset", sample, di);
    hold <= 1'h0;
    // Link start, phase reset during alignment and a new sync request.
    dev_wr(scc_pkg::A_LINKCTL, 8'h00);
    dev_wr(scc_pkg::A_LINKCTL, 8'h01);
    for (int r = 0; r < 2; r++) begin
      n = 0;
      while (nco !== 1'h1 && n < 600) begin
        @(posedge sys_clk);
        n++;
      end
      chk("nco reset", 32'h0000_0001, nco);
      pause(400);
      chk("nco released", 32'h0000_0000, nco);
      ahb(1'h1, scc_pkg::H_LINKCTL, 32'h0000_0003, 1'h0);
      pause(20);
      ahb(1'h1, scc_pkg::H_LINKCTL, 32'h0000_0001, 1'h0);
    end
    results();
  end
endmodule
`default_nettype wire
